//--- cpc_pkg.sv
// Purpose: Shared constants for the codec PLL / datapath / serial configuration bank
// Assumes: Register port with byte-wide data, page 0 offsets only
// Notes:   Field positions are bit indices inside an 8-bit register
package cpc_pkg;

   // Register offsets
   localparam logic [7:0] CPC_OFS_PLL_INT     = 8'h04;
   localparam logic [7:0] CPC_OFS_PLL_FRAC_HI = 8'h05;
   localparam logic [7:0] CPC_OFS_PLL_FRAC_LO = 8'h06;
   localparam logic [7:0] CPC_OFS_DATAPATH    = 8'h07;
   localparam logic [7:0] CPC_OFS_SERIAL_A    = 8'h08;

   // Reset values
   localparam logic [7:0] CPC_RST_PLL_INT     = 8'h04;
   localparam logic [7:0] CPC_RST_PLL_FRAC_HI = 8'h00;
   localparam logic [7:0] CPC_RST_PLL_FRAC_LO = 8'h00;
   localparam logic [7:0] CPC_RST_DATAPATH    = 8'h00;
   localparam logic [7:0] CPC_RST_SERIAL_A    = 8'h00;
   localparam logic [7:0] CPC_RD_UNMAPPED     = 8'h00;

   // Integer multiplier field
   localparam int CPC_INT_MSB      = 7;
   localparam int CPC_INT_LSB      = 2;
   localparam int CPC_INT_W        = 6;
   // Fractional multiplier
   localparam int CPC_FRAC_W       = 14;
   localparam int CPC_FRAC_LO_MSB  = 7;
   localparam int CPC_FRAC_LO_LSB  = 2;
   localparam logic [1:0] CPC_RSVD_LO_RD = 2'h0;
   localparam int CPC_FRAC_SCALE   = 10000;
   localparam int CPC_FACTOR_W     = 20;

   // Datapath setup fields
   localparam int CPC_DP_FSREF     = 7;
   localparam int CPC_DP_ADC_DUAL  = 6;
   localparam int CPC_DP_DAC_DUAL  = 5;
   localparam int CPC_DP_LSEL_MSB  = 4;
   localparam int CPC_DP_LSEL_LSB  = 3;
   localparam int CPC_DP_RSEL_MSB  = 2;
   localparam int CPC_DP_RSEL_LSB  = 1;

   // Serial control A fields
   localparam int CPC_SA_BCLK_DIR  = 7;
   localparam int CPC_SA_WCLK_DIR  = 6;
   localparam int CPC_SA_DOUT_TRI  = 5;
   localparam int CPC_SA_CLK_KEEP  = 4;
   localparam int CPC_SA_EFFECT_3D = 2;

   // Master clock generation defaults
   localparam int CPC_BCLK_HALF_DIV   = 8;
   localparam int CPC_BITS_PER_FRAME  = 64;

   localparam int CPC_SAMPLE_W = 16;

   // DAC path select codes
   typedef enum logic [1:0] {
      CPC_PATH_MUTE  = 2'h0,
      CPC_PATH_SAME  = 2'h1,
      CPC_PATH_SWAP  = 2'h2,
      CPC_PATH_MONO  = 2'h3
   } cpc_path_t;

endpackage : cpc_pkg

//--- cpc_pll_factor.sv
// Purpose: Effective PLL multiplication factor, scaled by the fraction base
// Assumes: Inputs stable while load is high
// Notes:   Factor = int * 10000 + frac, so the fraction keeps four decimals
`timescale 1ns/1ns
module cpc_pll_factor
   import cpc_pkg::*;
(
   // Clock and reset
   input  wire logic                    ref_clk,
   input  wire logic                    resetn,
   // Settings
   input  wire logic [CPC_INT_W-1:0]    int_mult,
   input  wire logic [CPC_FRAC_W-1:0]   frac_mult,
   input  wire logic                    load,
   // Result
   output      logic [CPC_FACTOR_W-1:0] factor_q
);

   localparam logic [CPC_FACTOR_W-1:0] SCALE = CPC_FACTOR_W'(CPC_FRAC_SCALE);
   localparam logic [CPC_FACTOR_W-1:0] RST_FACTOR = SCALE;

   logic [CPC_FACTOR_W-1:0] factor_d;

   always_comb begin
      factor_d = CPC_FACTOR_W'(CPC_FACTOR_W'(int_mult) * SCALE + CPC_FACTOR_W'(frac_mult));
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         factor_q <= RST_FACTOR;
      end else if (load) begin
         factor_q <= factor_d;
      end
   end

   AST_FACTOR_LOAD: assert property (@(posedge ref_clk) disable iff (!resetn)
      load |=> factor_q == $past(factor_d))
      else $error("PLL factor not taken on load");

endmodule : cpc_pll_factor

//--- cpc_clkgen.sv
// Purpose: Master-mode bit and word clock generation with pin enables
// Assumes: One ref_clk domain; pins are outputs only when master
// Notes:   Output enables are active low; clocks park low when stopped
`timescale 1ns/1ns
module cpc_clkgen
   import cpc_pkg::*;
#(
   parameter int HALF_DIV       = CPC_BCLK_HALF_DIV,
   parameter int BITS_PER_FRAME = CPC_BITS_PER_FRAME
)(
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic resetn,
   // Control
   input  wire logic bclk_master,
   input  wire logic wclk_master,
   input  wire logic run,
   // Pins
   output      logic bclk_o,
   output      logic bclk_oe_n,
   output      logic wclk_o,
   output      logic wclk_oe_n
);

   localparam int DIV_W = $clog2(HALF_DIV + 1);
   localparam int BIT_W = $clog2(BITS_PER_FRAME + 1);
   localparam logic [DIV_W-1:0] DIV_LAST  = DIV_W'(HALF_DIV - 1);
   localparam logic [BIT_W-1:0] HALF_LAST = BIT_W'(BITS_PER_FRAME / 2 - 1);

   logic [DIV_W-1:0] div_q;
   logic [BIT_W-1:0] bit_q;
   logic             tick;

   assign tick = run && (div_q == DIV_LAST);

   always_ff @(posedge ref_clk) begin
      if (!resetn || !run) begin
         div_q <= '0;
      end else begin
         div_q <= tick ? '0 : DIV_W'(div_q + 1'b1);
      end
   end

   // Word clock flips after half a frame of falling bit clock edges
   always_ff @(posedge ref_clk) begin
      if (!resetn || !run) begin
         bclk_o <= 1'b0;
         wclk_o <= 1'b0;
         bit_q  <= '0;
      end else if (tick) begin
         bclk_o <= !bclk_o;
         if (bclk_o) begin
            bit_q <= (bit_q == HALF_LAST) ? '0 : BIT_W'(bit_q + 1'b1);
            if (bit_q == HALF_LAST) begin
               wclk_o <= !wclk_o;
            end
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         bclk_oe_n <= 1'b1;
         wclk_oe_n <= 1'b1;
      end else begin
         bclk_oe_n <= !bclk_master;
         wclk_oe_n <= !wclk_master;
      end
   end

   AST_CLK_STOPPED: assert property (@(posedge ref_clk) disable iff (!resetn)
      !run ##1 !run |-> !bclk_o && !wclk_o)
      else $error("Master clocks toggling while stopped");

endmodule : cpc_clkgen

//--- cpc_config_bank.sv
// Purpose: Configuration bank for PLL multiplier, codec datapath and serial port
// Assumes: Page 0 selected; register port sampled on ref_clk
// Notes:   Read data appears one cycle after the read strobe
`timescale 1ns/1ns
module cpc_config_bank
   import cpc_pkg::*;
#(
   parameter int HALF_DIV       = CPC_BCLK_HALF_DIV,
   parameter int BITS_PER_FRAME = CPC_BITS_PER_FRAME
)(
   // Clock and reset
   input  wire logic                    ref_clk,
   input  wire logic                    resetn,
   // Register port
   input  wire logic [7:0]              reg_addr,
   input  wire logic [7:0]              reg_wdata,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   output      logic [7:0]              reg_rdata,
   // Codec status
   input  wire logic                    codec_powerdown,
   input  wire logic                    dout_valid,
   // Playback samples
   input  wire logic                    smp_valid,
   input  wire logic [CPC_SAMPLE_W-1:0] smp_left,
   input  wire logic [CPC_SAMPLE_W-1:0] smp_right,
   output      logic                    dac_valid,
   output      logic [CPC_SAMPLE_W-1:0] dac_left,
   output      logic [CPC_SAMPLE_W-1:0] dac_right,
   // PLL settings
   output      logic [CPC_INT_W-1:0]    pll_int_mult,
   output      logic [CPC_FRAC_W-1:0]   pll_frac_mult,
   output      logic [CPC_FACTOR_W-1:0] pll_factor,
   // Datapath controls
   output      logic                    ref_rate_441,
   output      logic                    adc_dual_rate,
   output      logic                    dac_dual_rate,
   output      logic                    effect_3d_en,
   // Serial port pins
   output      logic                    bclk_o,
   output      logic                    bclk_oe_n,
   output      logic                    wclk_o,
   output      logic                    wclk_oe_n,
   output      logic                    dout_oe_n
);

   // Storage
   logic [7:0]            pll_int_q;
   logic [7:0]            frac_hi_q;
   logic [7:0]            frac_hi_pend_q;
   logic [5:0]            frac_lo_q;
   logic [7:0]            datapath_q;
   logic [7:0]            serial_a_q;
   logic [CPC_FRAC_W-1:0] frac_d;
   logic                  frac_load;
   logic                  clk_run;
   logic                  clk_keep;
   logic                  bclk_seen_q;
   logic [7:0]            keep_still_q;
   logic                  wr_int;
   logic                  wr_hi;
   logic                  wr_lo;
   logic                  wr_dp;
   logic                  wr_sa;
   cpc_path_t             lsel;
   cpc_path_t             rsel;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   // Mono mix halves the sum so it cannot overflow
   function automatic logic [CPC_SAMPLE_W-1:0] route(input cpc_path_t sel,
                                                     input logic [CPC_SAMPLE_W-1:0] own,
                                                     input logic [CPC_SAMPLE_W-1:0] other);
      logic signed [CPC_SAMPLE_W:0] sum;
      sum = $signed({own[CPC_SAMPLE_W-1], own}) + $signed({other[CPC_SAMPLE_W-1], other});
      case (sel)
         CPC_PATH_MUTE: route = '0;
         CPC_PATH_SAME: route = own;
         CPC_PATH_SWAP: route = other;
         CPC_PATH_MONO: route = sum[CPC_SAMPLE_W:1];
         default:       route = '0;
      endcase
   endfunction : route

   assign wr_int = reg_wr && hit(reg_addr, CPC_OFS_PLL_INT);
   assign wr_hi  = reg_wr && hit(reg_addr, CPC_OFS_PLL_FRAC_HI);
   assign wr_lo  = reg_wr && hit(reg_addr, CPC_OFS_PLL_FRAC_LO);
   assign wr_dp  = reg_wr && hit(reg_addr, CPC_OFS_DATAPATH);
   assign wr_sa  = reg_wr && hit(reg_addr, CPC_OFS_SERIAL_A);

   // Integer multiplier; a zero code is the host's fault and is kept as written
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         pll_int_q <= CPC_RST_PLL_INT;
      end else if (wr_int) begin
         pll_int_q <= reg_wdata;
      end
   end

   // Fraction: upper byte is held pending until the lower bits arrive
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         frac_hi_pend_q <= CPC_RST_PLL_FRAC_HI;
      end else if (wr_hi) begin
         frac_hi_pend_q <= reg_wdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         frac_hi_q <= CPC_RST_PLL_FRAC_HI;
         frac_lo_q <= CPC_RST_PLL_FRAC_LO[CPC_FRAC_LO_MSB:CPC_FRAC_LO_LSB];
      end else if (wr_lo) begin
         frac_hi_q <= frac_hi_pend_q;
         frac_lo_q <= reg_wdata[CPC_FRAC_LO_MSB:CPC_FRAC_LO_LSB];
      end
   end

   assign frac_d    = {frac_hi_pend_q, reg_wdata[CPC_FRAC_LO_MSB:CPC_FRAC_LO_LSB]};
   assign frac_load = wr_lo || wr_int;

   // Datapath and serial control
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         datapath_q <= CPC_RST_DATAPATH;
      end else if (wr_dp) begin
         datapath_q <= reg_wdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         serial_a_q <= CPC_RST_SERIAL_A;
      end else if (wr_sa) begin
         serial_a_q <= reg_wdata;
      end
   end

   // Readback; unmapped offsets read zero
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         reg_rdata <= CPC_RD_UNMAPPED;
      end else if (reg_rd) begin
         case (reg_addr)
            CPC_OFS_PLL_INT:     reg_rdata <= pll_int_q;
            CPC_OFS_PLL_FRAC_HI: reg_rdata <= frac_hi_pend_q;
            CPC_OFS_PLL_FRAC_LO: reg_rdata <= {frac_lo_q, CPC_RSVD_LO_RD};
            CPC_OFS_DATAPATH:    reg_rdata <= datapath_q;
            CPC_OFS_SERIAL_A:    reg_rdata <= serial_a_q;
            default:             reg_rdata <= CPC_RD_UNMAPPED;
         endcase
      end
   end

   // Effective settings driven out
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         pll_int_mult  <= CPC_RST_PLL_INT[CPC_INT_MSB:CPC_INT_LSB];
         pll_frac_mult <= '0;
      end else begin
         if (wr_int) begin
            pll_int_mult <= reg_wdata[CPC_INT_MSB:CPC_INT_LSB];
         end
         if (wr_lo) begin
            pll_frac_mult <= frac_d;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         ref_rate_441  <= 1'b0;
         adc_dual_rate <= 1'b0;
         dac_dual_rate <= 1'b0;
         effect_3d_en  <= 1'b0;
      end else begin
         ref_rate_441  <= datapath_q[CPC_DP_FSREF];
         adc_dual_rate <= datapath_q[CPC_DP_ADC_DUAL];
         dac_dual_rate <= datapath_q[CPC_DP_DAC_DUAL];
         effect_3d_en  <= serial_a_q[CPC_SA_EFFECT_3D];
      end
   end

   // Factor uses the integer or fraction being written, else the one already stored
   cpc_pll_factor u_factor (
      .ref_clk   (ref_clk),
      .resetn    (resetn),
      .int_mult  (wr_int ? reg_wdata[CPC_INT_MSB:CPC_INT_LSB] : pll_int_q[CPC_INT_MSB:CPC_INT_LSB]),
      .frac_mult (wr_lo ? frac_d : {frac_hi_q, frac_lo_q}),
      .load      (frac_load),
      .factor_q  (pll_factor)
   );

   // Sample routing
   assign lsel = cpc_path_t'(datapath_q[CPC_DP_LSEL_MSB:CPC_DP_LSEL_LSB]);
   assign rsel = cpc_path_t'(datapath_q[CPC_DP_RSEL_MSB:CPC_DP_RSEL_LSB]);

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         dac_valid <= 1'b0;
         dac_left  <= '0;
         dac_right <= '0;
      end else begin
         dac_valid <= smp_valid;
         if (smp_valid) begin
            dac_left  <= route(lsel, smp_left, smp_right);
            dac_right <= route(rsel, smp_right, smp_left);
         end
      end
   end

   // Master clocks stop on power-down unless told to keep running
   assign clk_run = (serial_a_q[CPC_SA_BCLK_DIR] || serial_a_q[CPC_SA_WCLK_DIR]) &&
                    (!codec_powerdown || serial_a_q[CPC_SA_CLK_KEEP]);

   // Watch the pin itself, so a stuck divider is caught, not just the enable term
   assign clk_keep = serial_a_q[CPC_SA_BCLK_DIR] && codec_powerdown && serial_a_q[CPC_SA_CLK_KEEP];

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         bclk_seen_q  <= 1'b0;
         keep_still_q <= '0;
      end else begin
         bclk_seen_q  <= bclk_o;
         keep_still_q <= (!clk_keep || bclk_o != bclk_seen_q) ? '0 : 8'(keep_still_q + 1'b1);
      end
   end

   cpc_clkgen #(
      .HALF_DIV       (HALF_DIV),
      .BITS_PER_FRAME (BITS_PER_FRAME)
   ) u_clkgen (
      .ref_clk     (ref_clk),
      .resetn      (resetn),
      .bclk_master (serial_a_q[CPC_SA_BCLK_DIR]),
      .wclk_master (serial_a_q[CPC_SA_WCLK_DIR]),
      .run         (clk_run),
      .bclk_o      (bclk_o),
      .bclk_oe_n   (bclk_oe_n),
      .wclk_o      (wclk_o),
      .wclk_oe_n   (wclk_oe_n)
   );

   // Data output enable, active low
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         dout_oe_n <= 1'b0;
      end else begin
         dout_oe_n <= serial_a_q[CPC_SA_DOUT_TRI] && !dout_valid;
      end
   end

   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   sequence s_frac_hi_wr;
      wr_hi;
   endsequence

   sequence s_frac_lo_wr;
      wr_lo;
   endsequence

   AST_INT_FIELD: assert property (wr_int |=> pll_int_mult == $past(reg_wdata[CPC_INT_MSB:CPC_INT_LSB]))
      else $error("Integer multiplier not updated");

   AST_FRAC_PAIR: assert property (s_frac_hi_wr ##1 s_frac_lo_wr |=>
      pll_frac_mult[CPC_FRAC_W-1:CPC_FRAC_W-8] == $past(reg_wdata, 2))
      else $error("Fraction upper byte not from register 5");

   AST_FRAC_LOW: assert property (wr_lo |=>
      pll_frac_mult[5:0] == $past(reg_wdata[CPC_FRAC_LO_MSB:CPC_FRAC_LO_LSB]))
      else $error("Fraction low bits wrong");

   AST_FRAC_HOLD: assert property (wr_hi ##1 !wr_lo |=> $stable(pll_frac_mult))
      else $error("Fraction applied before register 6");

   AST_FACTOR: assert property (wr_lo |-> ##2
      pll_factor == CPC_FACTOR_W'(pll_int_mult) * CPC_FACTOR_W'(CPC_FRAC_SCALE) + CPC_FACTOR_W'(pll_frac_mult))
      else $error("Effective factor mismatch");

   AST_FSREF: assert property (wr_dp |=> ##1 ref_rate_441 == $past(reg_wdata[CPC_DP_FSREF], 2))
      else $error("Reference rate select not applied");

   AST_DUAL: assert property (wr_dp |=> ##1 adc_dual_rate == $past(reg_wdata[CPC_DP_ADC_DUAL], 2) &&
      dac_dual_rate == $past(reg_wdata[CPC_DP_DAC_DUAL], 2))
      else $error("Dual-rate enables not applied");

   AST_MUTE: assert property (smp_valid && lsel == CPC_PATH_MUTE && rsel == CPC_PATH_MUTE |=>
      dac_left == '0 && dac_right == '0)
      else $error("Muted path produced data");

   AST_SWAP: assert property (smp_valid && lsel == CPC_PATH_SWAP && rsel == CPC_PATH_SWAP |=>
      dac_left == $past(smp_right) && dac_right == $past(smp_left))
      else $error("Swapped path wrong");

   AST_BCLK_DIR: assert property (wr_sa ##1 !wr_sa |=> bclk_oe_n == !$past(reg_wdata[CPC_SA_BCLK_DIR], 2) &&
      wclk_oe_n == !$past(reg_wdata[CPC_SA_WCLK_DIR], 2))
      else $error("Clock pin direction wrong");

   AST_DOUT_TRI: assert property (serial_a_q[CPC_SA_DOUT_TRI] && !dout_valid |=> dout_oe_n)
      else $error("Data output driven while idle");

   AST_DOUT_DRIVE: assert property (!serial_a_q[CPC_SA_DOUT_TRI] |=> !dout_oe_n)
      else $error("Data output released with tri-state off");

   AST_3D: assert property (wr_sa |=> ##1 effect_3d_en == $past(reg_wdata[CPC_SA_EFFECT_3D], 2))
      else $error("3-D enable not applied");

   AST_KEEP_RUN: assert property (keep_still_q <= 8'(HALF_DIV))
      else $error("Master clocks stopped despite keep bit");

endmodule : cpc_config_bank

//--- cpc_host_model.sv
// Purpose: Host processor model driving the configuration register port
// Assumes: Requests change at the falling edge and are taken at the rising edge
// Notes:   Released address and data invert so stale values never look valid
`timescale 1ns/1ns
module cpc_host_model
   import cpc_pkg::*;
(
   // Clock
   input  wire logic       ref_clk,
   // Register port
   output      logic [7:0] reg_addr,
   output      logic [7:0] reg_wdata,
   output      logic       reg_wr,
   output      logic       reg_rd,
   input  wire logic [7:0] reg_rdata
);
   initial begin
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
   end

   task automatic put(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      reg_addr  <= a;
      reg_wr    <= 1'b1;
      if (a == CPC_OFS_PLL_INT || a == CPC_OFS_PLL_FRAC_LO) begin
         reg_wdata <= d & 8'hfc;
      end else if (a == CPC_OFS_DATAPATH) begin
         reg_wdata <= d & 8'hfe;
      end else begin
         reg_wdata <= d;
      end
   endtask : put

   // Bus released after each write and read; write_frac releases only after its second write
   task automatic idle;
      @(negedge ref_clk);
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b0;
      reg_addr  <= ~reg_addr;
      reg_wdata <= ~reg_wdata;
   endtask : idle

   task automatic write(input logic [7:0] a, input logic [7:0] d);
      put(a, d);
      idle();
   endtask : write

   // Extra cycle before sampling; read data holds anyway
   task automatic read(input logic [7:0] a, output logic [7:0] d);
      @(negedge ref_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      idle();
      @(negedge ref_clk);
      d = reg_rdata;
   endtask : read

   // Upper byte then lower six bits, back to back
   task automatic write_frac(input logic [13:0] f);
      logic [13:0] v;
      v = (f > 14'd9999) ? 14'd9999 : f;
      put(CPC_OFS_PLL_FRAC_HI, v[13:6]);
      put(CPC_OFS_PLL_FRAC_LO, {v[5:0], 2'b00});
      idle();
   endtask : write_frac

   // Read-modify-write keeps the reserved bit untouched
   task automatic write_serial(input logic [7:0] d);
      logic [7:0] cur;
      read(CPC_OFS_SERIAL_A, cur);
      write(CPC_OFS_SERIAL_A, {d[7:4], cur[3], d[2:0]});
   endtask : write_serial
endmodule : cpc_host_model

//--- test_codec_pll_datapath_serial_config.sv
// Purpose: Self-checking bench for the configuration bank
// Assumes: Short clock dividers HALF_DIV 2 and BITS_PER_FRAME 8
// Notes:   Waits after writes are generous, except the single-cycle wait before the rates check in test_midrun_reset; outputs are levels that hold
`timescale 1ns/1ns
module test_codec_pll_datapath_serial_config
   import cpc_pkg::*;
;
   logic        ref_clk, resetn, codec_powerdown, dout_valid, smp_valid;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, rd;
   logic        reg_wr, reg_rd, dac_valid, ref_rate_441, adc_dual_rate, dac_dual_rate;
   logic        effect_3d_en, bclk_o, bclk_oe_n, wclk_o, wclk_oe_n, dout_oe_n;
   logic [15:0] smp_left, smp_right, dac_left, dac_right;
   logic [5:0]  pll_int_mult;
   logic [13:0] pll_frac_mult;
   logic [19:0] pll_factor;
   int          err_count, tests_run;

   cpc_config_bank #(.HALF_DIV(2), .BITS_PER_FRAME(8)) DUT (
      .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .codec_powerdown(codec_powerdown),
      .dout_valid(dout_valid), .smp_valid(smp_valid), .smp_left(smp_left), .smp_right(smp_right),
      .dac_valid(dac_valid), .dac_left(dac_left), .dac_right(dac_right), .pll_int_mult(pll_int_mult),
      .pll_frac_mult(pll_frac_mult), .pll_factor(pll_factor), .ref_rate_441(ref_rate_441),
      .adc_dual_rate(adc_dual_rate), .dac_dual_rate(dac_dual_rate), .effect_3d_en(effect_3d_en),
      .bclk_o(bclk_o), .bclk_oe_n(bclk_oe_n), .wclk_o(wclk_o), .wclk_oe_n(wclk_oe_n),
      .dout_oe_n(dout_oe_n));

   cpc_host_model host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t %s seen %0h expected %0h", $time, what, seen, exp);
      end
   endtask : check

   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : complete_run

   function automatic logic [15:0] route(input logic [1:0] c, input logic [15:0] own, oth);
      logic [16:0] s;
      s = {own[15], own} + {oth[15], oth};
      case (c)
         2'h0: return 16'h0000;
         2'h1: return own;
         2'h2: return oth;
         default: return s[16:1];
      endcase
   endfunction : route

   task automatic test_reset;
      logic [7:0] ofs [5] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08};
      logic [7:0] rst [5] = '{8'h04, 8'h00, 8'h00, 8'h00, 8'h00};
      for (int i = 0; i < 5; i++) begin
         host.read(ofs[i], rd);
         check(rd, rst[i], "reset readback");
      end
      host.write(8'h09, 8'h5a);
      host.read(8'h09, rd);
      check(rd, 8'h00, "unmapped read");
      check(pll_factor, 20'd10000, "reset factor");
      check({bclk_oe_n, wclk_oe_n, dout_oe_n}, 3'b110, "reset pin enables");
      $display("test_reset done");
   endtask : test_reset

   task automatic test_pll;
      host.write(CPC_OFS_PLL_INT, 8'hff);
      repeat (3) @(negedge ref_clk);
      check(pll_int_mult, 6'd63, "integer multiplier");
      host.read(CPC_OFS_PLL_INT, rd);
      check(rd, 8'hfc, "reg4 readback");
      host.write_frac(14'd9999);
      repeat (3) @(negedge ref_clk);
      check(pll_frac_mult, 14'd9999, "fraction");
      check(pll_factor, 20'd639999, "factor");
      host.read(CPC_OFS_PLL_FRAC_LO, rd);
      check(rd, 8'h3c, "reg6 readback");
      host.write(CPC_OFS_PLL_FRAC_HI, 8'h01);
      repeat (3) @(negedge ref_clk);
      check(pll_frac_mult, 14'd9999, "fraction held until low write");
      host.write(CPC_OFS_PLL_FRAC_LO, 8'h04);
      repeat (3) @(negedge ref_clk);
      check(pll_frac_mult, 14'd65, "fraction applied");
      check(pll_factor, 20'd630065, "factor applied");
      $display("test_pll done");
   endtask : test_pll

   task automatic test_datapath;
      logic [1:0] c;
      for (int i = 0; i < 4; i++) begin
         c = i[1:0];
         host.write(CPC_OFS_DATAPATH, {c[0], c[1], c[1], c, c, 1'b0});
         repeat (3) @(negedge ref_clk);
         check({ref_rate_441, adc_dual_rate, dac_dual_rate}, {c[0], c[1], c[1]}, "rate bits");
         smp_left  <= 16'h7000 + 16'(i);
         smp_right <= 16'hb000 - 16'(i);
         smp_valid <= 1'b1;
         @(negedge ref_clk);
         smp_valid <= 1'b0;
         check(dac_valid, 1'b1, "sample valid");
         check(dac_left, route(c, smp_left, smp_right), "left route");
         check(dac_right, route(c, smp_right, smp_left), "right route");
      end
      $display("test_datapath done");
   endtask : test_datapath

   task automatic count_clk(input int eb, input int ew, input string what);
      logic pb, pw;
      int   nb, nw;
      nb = 0;
      nw = 0;
      @(negedge ref_clk);
      pb = bclk_o;
      pw = wclk_o;
      repeat (48) begin
         @(negedge ref_clk);
         nb += int'(bclk_o !== pb);
         nw += int'(wclk_o !== pw);
         pb = bclk_o;
         pw = wclk_o;
      end
      check(nb, eb, what);
      check(nw, ew, what);
   endtask : count_clk

   task automatic test_serial;
      host.write_serial(8'h80);
      repeat (3) @(negedge ref_clk);
      check({bclk_oe_n, wclk_oe_n}, 2'b01, "bit clock master only");
      host.write_serial(8'hc0);
      repeat (3) @(negedge ref_clk);
      check({bclk_oe_n, wclk_oe_n}, 2'b00, "both master");
      count_clk(24, 3, "clocks running");
      codec_powerdown <= 1'b1;
      repeat (4) @(negedge ref_clk);
      count_clk(0, 0, "clocks stopped");
      check({bclk_o, wclk_o}, 2'b00, "clocks parked low");
      host.write_serial(8'hd0);
      repeat (3) @(negedge ref_clk);
      count_clk(24, 3, "clocks kept");
      codec_powerdown <= 1'b0;
      host.write_serial(8'h24);
      repeat (3) @(negedge ref_clk);
      check(effect_3d_en, 1'b1, "effect enable");
      check(dout_oe_n, 1'b1, "data released");
      dout_valid <= 1'b1;
      repeat (2) @(negedge ref_clk);
      check(dout_oe_n, 1'b0, "data driven");
      host.read(CPC_OFS_SERIAL_A, rd);
      check(rd, 8'h24, "reg8 readback");
      $display("test_serial done");
   endtask : test_serial

   task automatic test_midrun_reset;
      host.write(CPC_OFS_DATAPATH, 8'he0);
      @(negedge ref_clk);
      check({ref_rate_441, adc_dual_rate, dac_dual_rate}, 3'b111, "rates before reset");
      resetn <= 1'b0;
      repeat (2) @(negedge ref_clk);
      resetn <= 1'b1;
      check({ref_rate_441, adc_dual_rate, dac_dual_rate, effect_3d_en}, 4'b0000, "rates after reset");
      check(pll_factor, 20'd10000, "factor after reset");
      host.read(CPC_OFS_SERIAL_A, rd);
      check(rd, 8'h00, "reg8 after reset");
      $display("test_midrun_reset done");
   endtask : test_midrun_reset

   initial begin
      resetn          = 1'b0;
      codec_powerdown = 1'b0;
      dout_valid      = 1'b0;
      smp_valid       = 1'b0;
      smp_left        = 16'h0000;
      smp_right       = 16'h0000;
      err_count       = 0;
      tests_run       = 0;
      repeat (8) @(posedge ref_clk);
      @(negedge ref_clk);
      resetn = 1'b1;
      test_reset();
      test_pll();
      test_datapath();
      test_serial();
      test_midrun_reset();
      complete_run();
   end

   // Whole run is well under two thousand cycles
   initial begin
      #200000;
      err_count++;
      complete_run();
   end
endmodule : test_codec_pll_datapath_serial_config
